// >>> design/line_status_irq_mask.sv
// Interrupt mask and receive event flag registers on the parallel host port.
// Assumes host strobes and receive events are one-cycle signals on core_clk.
`timescale 1ns/10ps
module line_status_irq_mask
    import line_status_irq_pkg::*;
#(
    parameter logic [4:0] ZERO_RUN_SEL0 = 5'h04,
    parameter logic [4:0] ZERO_RUN_SEL1 = 5'h08
)(
    input  wire logic                             core_clk,
    input  wire logic                             resetn,
    input  wire line_status_irq_pkg::host_req_t   hostReq,
    output logic [7:0]                            regRdData,
    input  wire line_status_irq_pkg::rx_events_t  rxEvents,
    input  wire logic                             lineStandardSelect,
    input  wire logic [7:0]                       alarmStatus,
    output logic                                  intN
);
    typedef struct packed {
        logic [7:0] mask;
        logic [7:0] pend;
        logic [7:0] srMask;
        logic [7:0] alarmPrev;
        logic [7:0] flags;
        logic [7:0] view;
        logic [7:0] rxMask;
        logic       carrierPrev;
        logic       onesPrev;
        logic [7:0] rdData;
        logic       intN;
    } irq_state_t;

    irq_state_t s_q, s_d;
    logic       hitSixteen;
    logic       hitSelected;
    logic [7:0] setFlags;
    logic [7:0] clrFlags;
    logic [7:0] setPend;
    logic [7:0] clrPend;
    logic       jitterNear;

    function automatic logic ended(input logic prev, input logic cur);
        ended = prev & ~cur;
    endfunction : ended

    function automatic logic hit(input host_req_t r, input logic strobe, input logic [7:0] a);
        hit = strobe && (r.addr == a);
    endfunction : hit

    zero_run_detect u_zero_run (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .bitValid     (rxEvents.bitValid),
        .bitIn        (rxEvents.bitIn),
        .selThreshold (lineStandardSelect ? ZERO_RUN_SEL1 : ZERO_RUN_SEL0),
        .hitSixteen   (hitSixteen),
        .hitSelected  (hitSelected)
    );

    always_comb begin
        s_d        = s_q;
        jitterNear = ({1'b0, rxEvents.jitterFill} + JITTER_MARGIN) >= {1'b0, rxEvents.jitterLimit};

        setFlags                   = 8'h00;
        setFlags[FLAG_ZERO_STRING] = hitSelected;
        setFlags[FLAG_SIXTEEN]     = hitSixteen;
        // Decode enable plays no part: the words are seen on the raw line
        setFlags[FLAG_CODE_WORD]   = lineStandardSelect ? rxEvents.b8zsWord : rxEvents.hdb3Word;
        setFlags[FLAG_CARRIER_CLR] = ended(s_q.carrierPrev, rxEvents.carrierLost);
        setFlags[FLAG_ONES_CLR]    = ended(s_q.onesPrev, rxEvents.allOnes);
        setFlags[FLAG_JITTER]      = jitterNear;

        // Only bits the host asked for and was shown are cleared on read
        clrFlags = hit(hostReq, hostReq.rd, ADDR_RX_FLAGS) ? (s_q.view & s_q.rxMask) : 8'h00;
        s_d.flags = ((s_q.flags & ~clrFlags) | setFlags) & RX_FLAGS_USED;

        if (hit(hostReq, hostReq.wr, ADDR_RX_FLAGS)) begin
            s_d.rxMask = hostReq.wdata;
            s_d.view   = (s_q.view & ~hostReq.wdata) | (s_q.flags & hostReq.wdata);
        end
        if (hit(hostReq, hostReq.wr, ADDR_IRQ_MASK)) begin
            s_d.mask = hostReq.wdata;
        end
        if (hit(hostReq, hostReq.wr, ADDR_ALARM_STATUS)) begin
            s_d.srMask = hostReq.wdata;
        end

        // Change-type alarms interrupt both ways, the rest only on rising
        setPend = ((alarmStatus ^ s_q.alarmPrev) & CHANGE_IRQ_BITS)
                | (alarmStatus & ~s_q.alarmPrev & ~CHANGE_IRQ_BITS);
        clrPend = hit(hostReq, hostReq.rd, ADDR_ALARM_STATUS) ? s_q.srMask : 8'h00;
        s_d.pend = (s_q.pend & ~clrPend) | setPend;
        s_d.intN = ~|(s_d.pend & s_d.mask);

        s_d.alarmPrev   = alarmStatus;
        s_d.carrierPrev = rxEvents.carrierLost;
        s_d.onesPrev    = rxEvents.allOnes;

        if (hostReq.rd) begin
            case (hostReq.addr)
                ADDR_ALARM_STATUS: s_d.rdData = alarmStatus;
                ADDR_IRQ_MASK:     s_d.rdData = s_q.mask;
                ADDR_RX_FLAGS:     s_d.rdData = s_q.view & RX_FLAGS_USED;
                default:           s_d.rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_q      <= '0;
            s_q.mask <= RESET_IRQ_MASK;
            s_q.flags <= RESET_RX_FLAGS;
            s_q.intN <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign regRdData = s_q.rdData;
    assign intN      = s_q.intN;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence changeSeen(int b);
        alarmStatus[b] != s_q.alarmPrev[b];
    endsequence

    // A read of the alarm register while no alarm moves in the same cycle
    sequence alarmReadQuiet;
        hit(hostReq, hostReq.rd, ADDR_ALARM_STATUS) ##0 alarmStatus == s_q.alarmPrev;
    endsequence

    sequence flagReadQuiet;
        hit(hostReq, hostReq.rd, ADDR_RX_FLAGS) ##0 setFlags == 8'h00;
    endsequence

    a_mask_write: assert property (hit(hostReq, hostReq.wr, ADDR_IRQ_MASK) |=> s_q.mask == $past(hostReq.wdata))
        else $error("mask write not stored");

    a_mask_read: assert property (hit(hostReq, hostReq.rd, ADDR_IRQ_MASK) |=> regRdData == $past(s_q.mask))
        else $error("mask read returned wrong value");

    a_irq_masked: assert property ((s_q.pend & s_q.mask) == 8'h00 |-> intN)
        else $error("interrupt low with nothing unmasked");

    a_irq_enabled: assert property ((s_q.pend & s_q.mask) != 8'h00 |-> !intN)
        else $error("unmasked pending alarm not driving interrupt");

    // Set beats clear, so a read of 06H in the same cycle cannot hide a fresh rise
    a_rise_drives: assert property ((alarmStatus & ~s_q.alarmPrev & s_q.mask) != 8'h00
        ##0 !hit(hostReq, hostReq.wr, ADDR_IRQ_MASK) |=> !intN)
        else $error("unmasked alarm rise did not pull interrupt low");

    a_fall_drives: assert property ((~alarmStatus & s_q.alarmPrev & s_q.mask & CHANGE_IRQ_BITS) != 8'h00
        ##0 !hit(hostReq, hostReq.wr, ADDR_IRQ_MASK) |=> !intN)
        else $error("change alarm fall did not pull interrupt low");

    a_carrier_change: assert property (changeSeen(BIT_CARRIER)
        ##0 !hit(hostReq, hostReq.rd, ADDR_ALARM_STATUS) |=> s_q.pend[BIT_CARRIER])
        else $error("carrier change did not pend");

    a_pend_steady: assert property (alarmStatus == s_q.alarmPrev
        ##0 !hit(hostReq, hostReq.rd, ADDR_ALARM_STATUS) |=> $stable(s_q.pend))
        else $error("pending alarms moved with no change or read");

    a_pend_release: assert property (alarmReadQuiet |=> (s_q.pend & $past(s_q.srMask)) == 8'h00)
        else $error("alarm read left selected bits pending");

    a_zero_string: assert property (hitSelected |=> s_q.flags[FLAG_ZERO_STRING])
        else $error("zero string flag not set");

    a_sixteen_flag: assert property (hitSixteen |=> s_q.flags[FLAG_SIXTEEN])
        else $error("sixteen zero flag not set");

    a_code_word: assert property (lineStandardSelect && rxEvents.b8zsWord |=> s_q.flags[FLAG_CODE_WORD])
        else $error("code word flag not set");

    a_hdb3_word: assert property (!lineStandardSelect && rxEvents.hdb3Word |=> s_q.flags[FLAG_CODE_WORD])
        else $error("hdb3 word flag not set");

    // A word of the other line standard must leave the flag alone
    a_code_other: assert property (!s_q.flags[FLAG_CODE_WORD]
        ##0 (lineStandardSelect ? !rxEvents.b8zsWord : !rxEvents.hdb3Word) |=> !s_q.flags[FLAG_CODE_WORD])
        else $error("code word flag set by the wrong line standard");

    a_carrier_clr: assert property (s_q.carrierPrev && !rxEvents.carrierLost |=> s_q.flags[FLAG_CARRIER_CLR])
        else $error("carrier clear flag not set");

    a_ones_clr: assert property (s_q.onesPrev && !rxEvents.allOnes |=> s_q.flags[FLAG_ONES_CLR])
        else $error("all ones clear flag not set");

    a_jitter_trip: assert property (jitterNear |=> s_q.flags[FLAG_JITTER])
        else $error("jitter trip flag not set");

    a_jitter_quiet: assert property (!jitterNear && !s_q.flags[FLAG_JITTER] |=> !s_q.flags[FLAG_JITTER])
        else $error("jitter trip flag set with fill far from limit");

    a_flags_keep: assert property (!hit(hostReq, hostReq.rd, ADDR_RX_FLAGS)
        |=> ($past(s_q.flags) & ~s_q.flags) == 8'h00)
        else $error("receive flag dropped without a read");

    a_flags_clear: assert property (flagReadQuiet
        |=> (s_q.flags & $past(s_q.view) & $past(s_q.rxMask)) == 8'h00)
        else $error("reported receive flag survived its read");

    a_view_refresh: assert property (hit(hostReq, hostReq.wr, ADDR_RX_FLAGS)
        |=> (s_q.view & $past(hostReq.wdata)) == ($past(s_q.flags) & $past(hostReq.wdata)))
        else $error("selected flag view not refreshed");

    a_view_hold: assert property (hit(hostReq, hostReq.wr, ADDR_RX_FLAGS)
        |=> (s_q.view & ~$past(hostReq.wdata)) == ($past(s_q.view) & ~$past(hostReq.wdata)))
        else $error("unselected flag view changed");

    a_view_read: assert property (hit(hostReq, hostReq.rd, ADDR_RX_FLAGS)
        |=> regRdData == ($past(s_q.view) & RX_FLAGS_USED))
        else $error("flag read did not return the view");

    a_read_steady: assert property (!hostReq.rd |=> $stable(regRdData))
        else $error("read data moved without a read");

    a_unused_zero: assert property (s_q.flags[1:0] == 2'b00 ##1 hostReq.rd && hostReq.addr == ADDR_RX_FLAGS
        |=> regRdData[1:0] == 2'b00)
        else $error("unassigned flag bits not zero");
endmodule : line_status_irq_mask

// >>> design/zero_run_detect.sv
// Consecutive-zero run counter with two threshold pulses.
// Assumes bitValid marks one received bit per pulse, on core_clk.
`timescale 1ns/10ps
module zero_run_detect
    import line_status_irq_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       bitValid,
    input  wire logic       bitIn,
    input  wire logic [4:0] selThreshold,
    output logic            hitSixteen,
    output logic            hitSelected
);
    typedef struct packed {
        logic [4:0] run;
        logic       hit16;
        logic       hitSel;
    } run_state_t;

    run_state_t s_q, s_d;

    // Count saturates so a long run fires each threshold exactly once
    always_comb begin
        s_d        = s_q;
        s_d.hit16  = 1'b0;
        s_d.hitSel = 1'b0;
        if (bitValid) begin
            if (bitIn) begin
                s_d.run = 5'h00;
            end else begin
                if (s_q.run != ZERO_RUN_MAX) begin
                    s_d.run = s_q.run + 5'h01;
                end
                s_d.hit16  = (s_q.run == SIXTEEN_ZERO_RUN - 5'h01);
                s_d.hitSel = (s_q.run == selThreshold - 5'h01);
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign hitSixteen  = s_q.hit16;
    assign hitSelected = s_q.hitSel;

    a_sixteen_hit: assert property (@(posedge core_clk) disable iff (!resetn)
        bitValid && !bitIn && s_q.run == 5'h0f |=> hitSixteen)
        else $error("sixteenth zero did not pulse");
endmodule : zero_run_detect

// >>> inc/line_status_irq_pkg.sv
// Constants, carriers and field layout for the line status interrupt block.
// Assumes all inputs come from logic on core_clk; no pin is sampled here.
// Summary of operation
// - Eight-bit mask at 07H; a one passes the same-position alarm to the interrupt.
// - Mask order loop-up, loop-down, tx clock, all ones, carrier, current, open, prbs.
// - Bit 6 latches on 16 or more consecutive zeros; cleared by reading.
// - Bit 5 latches on HDB3 word (select 0) or B8ZS word (select 1).
// - Bit 4 latches when carrier loss clears; cleared by reading.
// - Bit 3 latches when unframed all ones ends; cleared by reading.
// - Bit 2 latches when jitter FIFO fill is within 4 of its limit.
// - Host writes ones where it reads; only those positions refresh, others hold.
// - Carrier, all-ones and tx clock alarms interrupt on every change until read.
package line_status_irq_pkg;
    localparam logic [7:0] ADDR_ALARM_STATUS = 8'h06;
    localparam logic [7:0] ADDR_IRQ_MASK     = 8'h07;
    localparam logic [7:0] ADDR_RX_FLAGS     = 8'h08;

    localparam int BIT_LOOP_UP      = 7;
    localparam int BIT_LOOP_DOWN    = 6;
    localparam int BIT_TX_CLOCK     = 5;
    localparam int BIT_ALL_ONES     = 4;
    localparam int BIT_CARRIER      = 3;
    localparam int BIT_CURRENT      = 2;
    localparam int BIT_OPEN_CIRCUIT = 1;
    localparam int BIT_PRBS         = 0;

    localparam int FLAG_ZERO_STRING = 7;
    localparam int FLAG_SIXTEEN     = 6;
    localparam int FLAG_CODE_WORD   = 5;
    localparam int FLAG_CARRIER_CLR = 4;
    localparam int FLAG_ONES_CLR    = 3;
    localparam int FLAG_JITTER      = 2;

    localparam logic [7:0] RESET_IRQ_MASK   = 8'h00;
    localparam logic [7:0] RESET_RX_FLAGS   = 8'h00;
    localparam logic [7:0] RX_FLAGS_USED    = 8'hfc;
    localparam logic [7:0] CHANGE_IRQ_BITS  = 8'h38;
    localparam logic [4:0] SIXTEEN_ZERO_RUN = 5'h10;
    localparam logic [4:0] ZERO_RUN_MAX     = 5'h1f;
    localparam logic [8:0] JITTER_MARGIN    = 9'h004;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic       bitValid;
        logic       bitIn;
        logic       hdb3Word;
        logic       b8zsWord;
        logic       carrierLost;
        logic       allOnes;
        logic [7:0] jitterFill;
        logic [7:0] jitterLimit;
    } rx_events_t;
endpackage : line_status_irq_pkg

// >>> verification/host_model.sv
// Host processor model that drives the parallel register port.
// Assumes the bench calls its task; strobes change on falling edges only.
`timescale 1ns/10ps
module host_model
    import line_status_irq_pkg::*;
(
    input  wire logic                      core_clk,
    output line_status_irq_pkg::host_req_t hostReq
);
    initial hostReq = '0;

    // One strobe per access; released bus shows inverted values, not stale ones
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        hostReq <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge core_clk);
        hostReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : access
endmodule : host_model

// >>> verification/line_status_irq_mask_bench.sv
// Self-checking bench for the mask and receive event flag registers.
// Assumes host_model drives the port; read results are checked from a queue.
`timescale 1ns/10ps
module line_status_irq_mask_bench;
    import line_status_irq_pkg::*;
    logic       core_clk;
    logic       resetn;
    logic       lineStandardSelect;
    logic       intN;
    logic       sel;
    logic [7:0] alarmStatus, regRdData, m, j, expQ[$];
    host_req_t  hostReq;
    rx_events_t rxEvents;
    int         n_fail, n_tests, cyc;
    int         runs[7] = '{3, 4, 7, 8, 15, 16, 20};

    host_model host (.core_clk(core_clk), .hostReq(hostReq));
    line_status_irq_mask #(.ZERO_RUN_SEL0(5'h04), .ZERO_RUN_SEL1(5'h08)) uut (
        .core_clk(core_clk), .resetn(resetn), .hostReq(hostReq), .regRdData(regRdData),
        .rxEvents(rxEvents), .lineStandardSelect(lineStandardSelect),
        .alarmStatus(alarmStatus), .intN(intN));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic void check(logic [7:0] got, logic [7:0] want);
        n_tests++;
        if (got !== want) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endfunction : check

    // Read data is registered, so it is looked at one edge after the strobe
    always @(posedge core_clk) begin
        if (hostReq.rd) begin
            @(negedge core_clk);
            check(regRdData, expQ.pop_front());
        end
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    task automatic rdReg(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask : rdReg

    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d);
    endtask : wrReg

    // Refresh every flag, read and so clear them all
    task automatic flags(input logic [7:0] e);
        repeat (3) @(negedge core_clk);
        wrReg(ADDR_RX_FLAGS, 8'hfc);
        rdReg(ADDR_RX_FLAGS, e);
    endtask : flags

    task automatic clearAlarm(input int b);
        wrReg(ADDR_ALARM_STATUS, 8'h01 << b);
        rdReg(ADDR_ALARM_STATUS, alarmStatus);
        repeat (2) @(negedge core_clk);
    endtask : clearAlarm

    // A run of k zeros closed by a one, so the next run starts from nothing
    task automatic zeros(input int k);
        for (int i = 0; i <= k; i++) begin
            @(negedge core_clk);
            rxEvents.bitValid <= 1'b1;
            rxEvents.bitIn <= (i == k);
        end
        @(negedge core_clk);
        rxEvents.bitValid <= 1'b0;
    endtask : zeros

    initial begin
        void'($urandom(27974));
        resetn = 1'b0;
        lineStandardSelect = 1'b0;
        alarmStatus = 8'h00;
        rxEvents = '0;
        rxEvents.jitterLimit = 8'hff;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        check({7'h00, intN}, 8'h01);
        rdReg(ADDR_IRQ_MASK, RESET_IRQ_MASK);
        flags(8'h00);
        rdReg(8'h42, 8'h00);
        m = 8'($urandom);
        wrReg(ADDR_IRQ_MASK, m);
        rdReg(ADDR_IRQ_MASK, m);
        for (int b = 0; b < 8; b++) begin
            wrReg(ADDR_IRQ_MASK, 8'h00);
            alarmStatus[b] <= 1'b1;
            repeat (3) @(negedge core_clk);
            check({7'h00, intN}, 8'h01);
            wrReg(ADDR_IRQ_MASK, 8'h01 << b);
            repeat (2) @(negedge core_clk);
            check({7'h00, intN}, 8'h00);
            clearAlarm(b);
            check({7'h00, intN}, 8'h01);
            alarmStatus[b] <= 1'b0;
            repeat (3) @(negedge core_clk);
            check({7'h00, intN}, (b >= 3 && b <= 5) ? 8'h00 : 8'h01);
            clearAlarm(b);
        end
        wrReg(ADDR_IRQ_MASK, 8'h00);
        foreach (runs[i]) begin
            sel = 1'($urandom_range(1));
            lineStandardSelect <= sel;
            zeros(runs[i]);
            flags({runs[i] >= (sel ? 8 : 4), runs[i] >= 16, 6'h00});
        end
        for (int c = 0; c < 8; c++) begin
            lineStandardSelect <= c[2];
            @(negedge core_clk);
            rxEvents.hdb3Word <= c[0];
            rxEvents.b8zsWord <= c[1];
            @(negedge core_clk);
            rxEvents.hdb3Word <= 1'b0;
            rxEvents.b8zsWord <= 1'b0;
            flags({2'b00, c[2] ? c[1] : c[0], 5'h00});
        end
        flags(8'h00);
        rxEvents.carrierLost <= 1'b1;
        rxEvents.allOnes <= 1'b1;
        repeat (2) @(negedge core_clk);
        rxEvents.carrierLost <= 1'b0;
        rxEvents.allOnes <= 1'b0;
        repeat (3) @(negedge core_clk);
        wrReg(ADDR_RX_FLAGS, 8'h10);
        rdReg(ADDR_RX_FLAGS, 8'h10);
        wrReg(ADDR_RX_FLAGS, 8'h18);
        rdReg(ADDR_RX_FLAGS, 8'h08);
        flags(8'h00);
        j = 8'($urandom_range(250, 10));
        rxEvents.jitterLimit <= j;
        rxEvents.jitterFill <= j - 8'h05;
        flags(8'h00);
        rxEvents.jitterFill <= j - 8'h04;
        repeat (2) @(negedge core_clk);
        rxEvents.jitterFill <= 8'h00;
        flags(8'h04);
        repeat (3) @(negedge core_clk);
        close_out();
    end
endmodule : line_status_irq_mask_bench
